// ---- hw/rpc_ctrl.sv ----
`timescale 1ns/1ps
`include "rpc_cfg.svh"

// Behaviour
// - four extra objects when option enabled
// - control word at index 4200
// - status word at index 4201
// - control word 16-bit read/write, SDO only
// - bit 0 requests reconfiguration
// - never enter run without start request
// - requests during test mode ignored, flagged
// - status word 16-bit read-only progress/errors
// - status 0000 idle or in progress
// - mask applied reports 0001, waits start
// - start done reports 0002, exchange allowed
// - failures report 0100 or 0200
// - malformed request refused with 1000
// - foreign module marked absent gives 1100
// - tool in control gives 1200
// - only defined status codes ever produced
// - write mask at 4202, count two
// - second mask subindex ignored
// - write mask reads of subindex 1 and 2 answer abort
// - set bit absent, clear bit present
// - mask in use readable subindex 1
// - readback mask at index 4203
// - busy, store mask, reboot, then 0001
module rpc_ctrl (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     opt_en,
  input  wire logic                     test_mode,
  input  wire logic                     tool_ctrl,
  input  wire rpc_pkg::rpc_sdo_req_type sdo_req,
  output rpc_pkg::rpc_sdo_rsp_type      sdo_rsp,
  input  wire logic [31:0]              foreign_map,
  input  wire logic                     nv_done,
  input  wire logic                     nv_fail,
  input  wire logic                     boot_done,
  input  wire logic                     boot_fail,
  input  wire logic                     run_done,
  input  wire logic                     run_fail,
  output logic                          nv_store_req,
  output logic [31:0]                   nv_store_mask,
  output logic                          boot_req,
  output logic                          run_req,
  output logic                          data_exchange_en,
  output logic [15:0]                   island_status_word
);
  import rpc_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0]      pin_meta_q;
  logic [2:0]      pin_sync_q;
  logic            opt_en_s;
  logic            test_mode_s;
  logic            tool_ctrl_s;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {tool_ctrl, test_mode, opt_en};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign opt_en_s    = pin_sync_q[0];
  assign test_mode_s = pin_sync_q[1];
  assign tool_ctrl_s = pin_sync_q[2];

  // ************************************************************
  // state and registers
  // ************************************************************
  rpc_state_type   state_q;
  rpc_state_type   state_d;
  logic [15:0]     ctrl_q;
  logic [15:0]     status_q;
  logic [15:0]     status_d;
  logic [31:0]     mask_wr_q;
  logic [31:0]     mask_use_q;
  rpc_sdo_rsp_type rsp_q;
  rpc_sdo_rsp_type rsp_d;
  logic            nv_req_q;
  logic            boot_req_q;
  logic            run_req_q;
  logic            exch_q;

  // ************************************************************
  // object decode
  // ************************************************************
  // objects exist only with option
  wire hit_ctrl   = opt_en_s && (sdo_req.index == `RPC_IDX_CTRL);
  wire hit_stat   = opt_en_s && (sdo_req.index == `RPC_IDX_STAT);
  wire hit_mwr    = opt_en_s && (sdo_req.index == `RPC_IDX_MASK_WR);
  wire hit_mrb    = opt_en_s && (sdo_req.index == `RPC_IDX_MASK_RB);
  wire sub0       = (sdo_req.sub == `RPC_SUB_COUNT);
  wire sub1       = (sdo_req.sub == `RPC_SUB_MASK_LO);
  wire sub2       = (sdo_req.sub == `RPC_SUB_MASK_HI);
  wire rd         = sdo_req.valid && !sdo_req.write;
  wire wr         = sdo_req.valid && sdo_req.write;

  wire wr_ctrl    = wr && hit_ctrl && sub0;
  wire rd_ctrl    = rd && hit_ctrl && sub0;
  wire rd_stat    = rd && hit_stat && sub0;
  wire rd_mwr_cnt = rd && hit_mwr && sub0;
  wire wr_mask_lo = wr && hit_mwr && sub1;
  wire wr_mask_hi = wr && hit_mwr && sub2;
  wire rd_mrb_cnt = rd && hit_mrb && sub0;
  wire rd_mrb_lo  = rd && hit_mrb && sub1;
  wire rd_mrb_hi  = rd && hit_mrb && sub2;
  // everything else, including write mask subindex 1 and 2 reads, aborts
  wire acc_ok     = wr_ctrl | rd_ctrl | rd_stat | rd_mwr_cnt | wr_mask_lo | wr_mask_hi
                  | rd_mrb_cnt | rd_mrb_lo | rd_mrb_hi;

  // ************************************************************
  // control request classification
  // ************************************************************
  // bit 0 alone asks for reconfiguration
  wire is_recfg   = (sdo_req.data[15:0] == `RPC_CTRL_RECFG);
  // bit 1 alone asks for start
  wire is_start   = (sdo_req.data[15:0] == `RPC_CTRL_START);
  wire is_none    = (sdo_req.data[15:0] == `RPC_CTRL_RESET);
  wire busy_st    = (state_q == RPC_STORE) || (state_q == RPC_BOOT) || (state_q == RPC_START);
  // a foreign module may never be marked absent
  wire foreign_bad = |(mask_wr_q & foreign_map);

  wire ref_test   = wr_ctrl && test_mode_s;
  wire ref_tool   = wr_ctrl && !test_mode_s && tool_ctrl_s;
  // a request while busy is dropped without trace, master must wait
  wire drop_busy  = wr_ctrl && !test_mode_s && !tool_ctrl_s && busy_st;
  wire ctrl_free  = wr_ctrl && !test_mode_s && !tool_ctrl_s && !busy_st;
  // unknown value, or start in idle or running (start while busy is dropped)
  wire ref_wrong  = ctrl_free && !is_none && ((!is_recfg && !is_start)
                  || (is_start && state_q != RPC_READY));
  wire ref_foreign = ctrl_free && is_recfg && foreign_bad;
  wire go_recfg   = ctrl_free && is_recfg && !foreign_bad;
  wire go_start   = ctrl_free && is_start && (state_q == RPC_READY);
  wire ctrl_store = ctrl_free && !ref_wrong && !ref_foreign;

  // ************************************************************
  // sequencer
  // ************************************************************
  // busy, store, reboot, done; run only on start
  always_comb
  begin
    state_d  = state_q;
    status_d = status_q;
    unique case (state_q)
      RPC_IDLE, RPC_READY, RPC_RUNNING:
      begin
        if (go_recfg)
        begin
          state_d  = RPC_STORE;
          status_d = `RPC_ST_BUSY;
        end
        else if (go_start)
        begin
          state_d  = RPC_START;
          status_d = `RPC_ST_BUSY;
        end
      end
      RPC_STORE:
      begin
        if (nv_fail)
        begin
          state_d  = RPC_IDLE;
          status_d = `RPC_ST_RECFG_FAIL;
        end
        else if (nv_done)
          state_d = RPC_BOOT;
      end
      RPC_BOOT:
      begin
        if (boot_fail)
        begin
          state_d  = RPC_IDLE;
          status_d = `RPC_ST_RECFG_FAIL;
        end
        else if (boot_done)
        begin
          state_d  = RPC_READY;
          status_d = `RPC_ST_RECFG_DONE;
        end
      end
      RPC_START:
      begin
        // failed start stays ready to retry
        if (run_fail)
        begin
          state_d  = RPC_READY;
          status_d = `RPC_ST_START_FAIL;
        end
        else if (run_done)
        begin
          state_d  = RPC_RUNNING;
          status_d = `RPC_ST_START_DONE;
        end
      end
    endcase
    // refusal codes are the only other values
    if (ref_test || ref_wrong)
      status_d = `RPC_ST_WRONG;
    else if (ref_tool)
      status_d = `RPC_ST_TOOL;
    else if (ref_foreign)
      status_d = `RPC_ST_FOREIGN;
  end

  // status is 0000 out of reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q  <= RPC_IDLE;
      status_q <= `RPC_ST_BUSY;
    end
    else
    begin
      state_q  <= state_d;
      status_q <= status_d;
    end
  end

  // ************************************************************
  // object storage
  // ************************************************************
  // control word keeps accepted values; mask kept raw
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q     <= `RPC_CTRL_RESET;
      mask_wr_q  <= `RPC_MASK_RESET;
      mask_use_q <= `RPC_MASK_RESET;
    end
    else
    begin
      if (ctrl_store)
        ctrl_q <= sdo_req.data[15:0];
      if (wr_mask_lo)
        mask_wr_q <= sdo_req.data;
      // mask in use follows a successful reboot
      if (state_q == RPC_BOOT && boot_done && !boot_fail)
        mask_use_q <= mask_wr_q;
    end
  end

  // ************************************************************
  // island handshakes
  // ************************************************************
  // one-cycle request pulses; exchange opens only after start
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      nv_req_q   <= 1'b0;
      boot_req_q <= 1'b0;
      run_req_q  <= 1'b0;
      exch_q     <= 1'b0;
    end
    else
    begin
      nv_req_q   <= go_recfg;
      boot_req_q <= (state_q == RPC_STORE) && nv_done && !nv_fail;
      run_req_q  <= go_start;
      exch_q     <= (state_d == RPC_RUNNING);
    end
  end

  // ************************************************************
  // sdo answer
  // ************************************************************
  // status read back, never written
  always_comb
  begin
    rsp_d.valid = sdo_req.valid;
    rsp_d.abort = sdo_req.valid && !acc_ok;
    rsp_d.data  = 32'h0000_0000;
    if (rd_ctrl)
      rsp_d.data = {16'h0000, ctrl_q};
    else if (rd_stat)
      rsp_d.data = {16'h0000, status_q};
    else if (rd_mwr_cnt || rd_mrb_cnt)
      rsp_d.data = `RPC_SUB_COUNT_VAL;
    else if (rd_mrb_lo)
      rsp_d.data = mask_use_q;
    else if (rd_mrb_hi)
      rsp_d.data = 32'h0000_0000;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rsp_q <= '0;
    else
      rsp_q <= rsp_d;
  end

  assign sdo_rsp            = rsp_q;
  // bit n is island position n+1, passed unchanged
  assign nv_store_mask      = mask_wr_q;
  assign nv_store_req       = nv_req_q;
  assign boot_req           = boot_req_q;
  assign run_req            = run_req_q;
  assign data_exchange_en   = exch_q;
  assign island_status_word = status_q;

  // ************************************************************
  // assertions
  // ************************************************************
  a_test_refusal: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_ctrl && test_mode_s) |=> (island_status_word == `RPC_ST_WRONG) && !nv_store_req && !run_req)
    else $error("test mode request not refused");

  a_tool_refusal: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_ctrl && !test_mode_s && tool_ctrl_s) |=> (island_status_word == `RPC_ST_TOOL))
    else $error("tool control request not refused");

  a_foreign_refusal: assert property (@(posedge clk) disable iff (sys_rst)
    (ctrl_free && is_recfg && |(mask_wr_q & foreign_map)) |=> (island_status_word == `RPC_ST_FOREIGN))
    else $error("foreign absent mask not refused");

  a_recfg_busy: assert property (@(posedge clk) disable iff (sys_rst)
    go_recfg |=> nv_store_req && (island_status_word == `RPC_ST_BUSY) && (nv_store_mask == $past(mask_wr_q)))
    else $error("reconfiguration did not start storage busy");

  a_recfg_done: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == RPC_BOOT && boot_done && !boot_fail)
      |=> (island_status_word == `RPC_ST_RECFG_DONE) && (mask_use_q == mask_wr_q) && !data_exchange_en)
    else $error("reconfiguration done not reported");

  a_boot_after_store: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == RPC_STORE && nv_done && !nv_fail) |=> boot_req && (island_status_word == `RPC_ST_BUSY))
    else $error("reboot not requested after storage");

  a_run_gated: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(data_exchange_en) |-> $past(state_q) == RPC_START && $past(run_done))
    else $error("run entered without start request");

  a_start_done: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == RPC_START && run_done && !run_fail)
      |=> (island_status_word == `RPC_ST_START_DONE) && data_exchange_en)
    else $error("start done not reported");

  a_fail_codes: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == RPC_START && run_fail) |=> (island_status_word == `RPC_ST_START_FAIL))
    else $error("start failure not reported");

  a_status_legal: assert property (@(posedge clk) disable iff (sys_rst)
    island_status_word inside {`RPC_ST_BUSY, `RPC_ST_RECFG_DONE, `RPC_ST_START_DONE, `RPC_ST_RECFG_FAIL,
                               `RPC_ST_START_FAIL, `RPC_ST_WRONG, `RPC_ST_FOREIGN, `RPC_ST_TOOL})
    else $error("reserved status code produced");

  a_mask_read_abort: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && hit_mwr && !sub0) |=> sdo_rsp.valid && sdo_rsp.abort)
    else $error("write mask read not aborted");

  a_hi_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_mask_hi && !wr_mask_lo) |=> $stable(mask_wr_q) && sdo_rsp.valid && !sdo_rsp.abort)
    else $error("second mask word not ignored");

  a_readback_mask: assert property (@(posedge clk) disable iff (sys_rst)
    rd_mrb_lo |=> sdo_rsp.data == $past(mask_use_q) && !sdo_rsp.abort)
    else $error("readback mask wrong");

endmodule

// ---- hw/rpc_cfg.svh ----
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH

// object dictionary indices and subindices
`define RPC_IDX_CTRL      16'h4200
`define RPC_IDX_STAT      16'h4201
`define RPC_IDX_MASK_WR   16'h4202
`define RPC_IDX_MASK_RB   16'h4203
`define RPC_SUB_COUNT     8'h00
`define RPC_SUB_MASK_LO   8'h01
`define RPC_SUB_MASK_HI   8'h02
`define RPC_SUB_COUNT_VAL 32'h0000_0002

// control word request values and bit positions
`define RPC_CTRL_RECFG_BIT 0
`define RPC_CTRL_START_BIT 1
`define RPC_CTRL_RECFG     16'h0001
`define RPC_CTRL_START     16'h0002
`define RPC_CTRL_RESET     16'h0000

// status word codes
`define RPC_ST_BUSY        16'h0000
`define RPC_ST_RECFG_DONE  16'h0001
`define RPC_ST_START_DONE  16'h0002
`define RPC_ST_RECFG_FAIL  16'h0100
`define RPC_ST_START_FAIL  16'h0200
`define RPC_ST_WRONG       16'h1000
`define RPC_ST_FOREIGN     16'h1100
`define RPC_ST_TOOL        16'h1200

// reset values
`define RPC_MASK_RESET     32'h0000_0000

`endif

// ---- hw/rpc_pkg.sv ----
package rpc_pkg;

  // one object dictionary access from the transfer layer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } rpc_sdo_req_type;

  // answer to that access, one cycle later
  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] data;
  } rpc_sdo_rsp_type;

  typedef enum logic [2:0] {
    RPC_IDLE    = 3'b000,
    RPC_STORE   = 3'b001,
    RPC_BOOT    = 3'b010,
    RPC_READY   = 3'b011,
    RPC_START   = 3'b100,
    RPC_RUNNING = 3'b101
  } rpc_state_type;

endpackage

// ---- dv/rpc_island_model.sv ----
`timescale 1ns/1ps

// ****************************************
// storage and island bus stand-in
// ****************************************
module rpc_island_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       nv_store_req,
  input  wire logic       boot_req,
  input  wire logic       run_req,
  input  wire logic [7:0] delay,
  input  wire logic [2:0] fail_sel,
  output logic            nv_done,
  output logic            nv_fail,
  output logic            boot_done,
  output logic            boot_fail,
  output logic            run_done,
  output logic            run_fail
);
  logic       busy_q;
  logic [7:0] cnt_q;
  logic [2:0] kind_q;
  logic [2:0] end_d;

  // job that finishes this cycle; delay lets the bench try prompt and slow answers
  assign end_d = (busy_q && cnt_q == 8'h00) ? kind_q : 3'h0;

  // one job at a time: the block never overlaps store, reboot and run
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
      kind_q <= 3'h0;
      {run_done, boot_done, nv_done} <= 3'h0;
      {run_fail, boot_fail, nv_fail} <= 3'h0;
    end
    else
    begin
      {run_done, boot_done, nv_done} <= end_d & ~fail_sel;
      {run_fail, boot_fail, nv_fail} <= end_d & fail_sel;
      if (|{run_req, boot_req, nv_store_req})
      begin
        busy_q <= 1'b1;
        cnt_q  <= delay;
        kind_q <= {run_req, boot_req, nv_store_req};
      end
      else if (end_d != 3'h0)
        busy_q <= 1'b0;
      else if (busy_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// ---- dv/rpc_ctrl_test.sv ----
`timescale 1ns/1ps

module rpc_ctrl_test;
  import rpc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, opt_en = 1'b1, test_mode = 1'b0, tool_ctrl = 1'b0;
  rpc_sdo_req_type sdo_req = '0;
  rpc_sdo_rsp_type sdo_rsp, rsp;
  logic [31:0] foreign_map = 32'h0;
  logic [7:0]  delay = 8'h00;
  logic [2:0]  fail_sel = 3'h0;
  logic nv_done, nv_fail, boot_done, boot_fail, run_done, run_fail;
  logic nv_store_req, boot_req, run_req, data_exchange_en;
  logic [31:0] nv_store_mask;
  logic [15:0] island_status_word;
  int n_errors = 0, comparisons = 0;

  rpc_ctrl rpc_ctrl_i (.clk(clk), .sys_rst(sys_rst), .opt_en(opt_en), .test_mode(test_mode),
    .tool_ctrl(tool_ctrl), .sdo_req(sdo_req), .sdo_rsp(sdo_rsp), .foreign_map(foreign_map),
    .nv_done(nv_done), .nv_fail(nv_fail), .boot_done(boot_done), .boot_fail(boot_fail),
    .run_done(run_done), .run_fail(run_fail), .nv_store_req(nv_store_req),
    .nv_store_mask(nv_store_mask), .boot_req(boot_req), .run_req(run_req),
    .data_exchange_en(data_exchange_en), .island_status_word(island_status_word));

  rpc_island_model rpc_island_model_i (.clk(clk), .sys_rst(sys_rst), .nv_store_req(nv_store_req),
    .boot_req(boot_req), .run_req(run_req), .delay(delay), .fail_sel(fail_sel),
    .nv_done(nv_done), .nv_fail(nv_fail), .boot_done(boot_done), .boot_fail(boot_fail),
    .run_done(run_done), .run_fail(run_fail));

  // ****************************************
  // shared tasks
  // ****************************************
  initial
  begin
    forever #20 clk = ~clk;
  end

  // one bit wider than a data word so that the abort flag travels with the data
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held through the taking edge, answer sampled in the cycle after it
  task automatic sdo(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    @(posedge clk);
    sdo_req <= '{1'b1, w, idx, sub, d};
    @(posedge clk);
    sdo_req.valid <= 1'b0;
    #1 rsp = sdo_rsp;
  endtask

  // bounded wait; a hang shows up as a mismatch rather than a stall
  task automatic wait_status(input logic [15:0] exp);
    for (int i = 0; i < 400 && island_status_word !== exp; i++)
      @(posedge clk) #1;
    chk(island_status_word, exp);
  endtask

  task automatic pins(input logic tm, input logic tc);
    @(posedge clk);
    test_mode <= tm;
    tool_ctrl <= tc;
    repeat (3) @(posedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_objects;
    chk(island_status_word, 32'h0);
    sdo(1'b0, 16'h4201, 8'h00, 32'h0); chk({rsp.abort, rsp.data}, 33'h0);
    sdo(1'b0, 16'h4202, 8'h01, 32'h0); chk(rsp.abort, 1'b1);
    sdo(1'b0, 16'h4202, 8'h00, 32'h0); chk({rsp.abort, rsp.data}, 33'h2);
    sdo(1'b1, 16'h4201, 8'h00, 32'h1); chk(rsp.abort, 1'b1);
    sdo(1'b1, 16'h4204, 8'h00, 32'h1); chk(rsp.abort, 1'b1);
  endtask

  // master loads the mask before setting the request bit
  task automatic t_reconfig(input logic [31:0] mask, input logic [15:0] exp);
    sdo(1'b1, 16'h4202, 8'h01, mask);
    sdo(1'b1, 16'h4202, 8'h02, ~mask); chk(rsp.abort, 1'b0);
    sdo(1'b1, 16'h4200, 8'h00, 32'h1); chk({rsp.valid, rsp.abort}, 2'b10);
    chk(island_status_word, 32'h0);
    chk(nv_store_mask, mask);
    wait_status(exp);
    chk(data_exchange_en, 1'b0);
  endtask

  // start only once reconfiguration is reported done
  task automatic t_start(input logic [15:0] exp);
    sdo(1'b1, 16'h4200, 8'h00, 32'h2);
    chk(run_req, 1'b1);
    wait_status(exp);
    chk(data_exchange_en, exp == 16'h0002);
  endtask

  task automatic t_ctrl_refused(input logic [15:0] val, input logic [15:0] exp);
    sdo(1'b1, 16'h4200, 8'h00, {16'h0, val}); chk(rsp.abort, 1'b0);
    wait_status(exp);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_objects;
    // one request at a time, next one only after completion status
    t_reconfig(32'h0000_0084, 16'h0001);
    sdo(1'b0, 16'h4203, 8'h01, 32'h0); chk(rsp.data, 32'h0000_0084);
    sdo(1'b0, 16'h4203, 8'h02, 32'h0); chk(rsp.data, 32'h0);
    t_start(16'h0002);
    sdo(1'b0, 16'h4200, 8'h00, 32'h0); chk(rsp.data, 32'h2);
    t_ctrl_refused(16'h0002, 16'h1000);
    foreign_map <= 32'h8000_0000;
    sdo(1'b1, 16'h4202, 8'h01, 32'h8000_0000);
    t_ctrl_refused(16'h0001, 16'h1100);
    foreign_map <= 32'h0;
    pins(1'b1, 1'b0);
    t_ctrl_refused(16'h0001, 16'h1000);
    pins(1'b0, 1'b1);
    t_ctrl_refused(16'h0001, 16'h1200);
    pins(1'b0, 1'b0);
    t_ctrl_refused(16'h0003, 16'h1000);
    // slow island, then the store and start failure paths
    delay <= 8'd20;
    fail_sel <= 3'b001;
    t_reconfig(32'h0000_0001, 16'h0100);
    fail_sel <= 3'b100;
    t_reconfig(32'h0000_0001, 16'h0001);
    t_start(16'h0200);
    fail_sel <= 3'b000;
    t_start(16'h0002);
    @(posedge clk);
    opt_en <= 1'b0;
    repeat (3) @(posedge clk);
    sdo(1'b0, 16'h4201, 8'h00, 32'h0); chk(rsp.abort, 1'b1);
    results;
  end

  initial
  begin
    #(40 * 20000);
    n_errors++;
    results;
  end
endmodule
